// >>> include/mcls_consts.svh
`ifndef MCLS_CONSTS_SVH
`define MCLS_CONSTS_SVH
// Period, dead time and list widths
`define MCLS_CNT_W 16
`define MCLS_DT_W 8
`define MCLS_LIST_DEPTH 8
`define MCLS_IDX_W 3
// Fetch windows after a reload, in bus cycles
`define MCLS_PTU_FETCH_CYC 4'h7
`define MCLS_ADC_FETCH_CYC 4'hA
// Conversion length in bus cycles (arbitrary plain default)
`define MCLS_CONV_CYC 4'h8
`define MCLS_CNT_RST 16'h0000
`endif

// >>> include/mcls_pkg.sv
`include "mcls_consts.svh"
package mcls_pkg;
    typedef enum logic [3:0] {
        MCLS_ADC_IDLE = 4'h1,
        MCLS_ADC_FETCH = 4'h2,
        MCLS_ADC_CONV = 4'h4,
        MCLS_ADC_ABORT = 4'h8
    } mcls_adc_state_t;
    typedef logic [`MCLS_CNT_W-1:0] mcls_cnt_t;
endpackage

// >>> hdl/mcls_top.sv
// Summary of operation
// [RQ1] Dead time is a whole count of bus clock cycles from its config input.
// [RQ2] Static mode: software changes only duty values between cycles.
// [RQ3] Reload event is produced once every n PWM periods.
// [RQ4] Config selects whether a commutation trigger propagates or is blocked.
// [RQ5] ADC preloads next first command after a sequence, then waits idle.
// [RQ6] Trigger unit fires at each list time until reload or async reload.
// [RQ7] Software reads results, clears flag, writes duty, sets load-ok.
// [RQ8] Dynamic mode: software prepares cycle n settings during cycle n-1.
// [RQ9] Any gate fault disables FETs and forces PWM outputs inactive.
// [RQ10] Clear gate fault then PWM fault; driving resumes at next period.
// [RQ11] Reload without load-ok in time flags reload overrun error.
// [RQ12] Static-mode sequence errors suggest corruption; shut loop down.
// [RQ13] Dynamic-mode sequence errors mean mismatched settings.
// [RQ14] Commutation restarts counter and reinitialises pattern and dead time.
// [RQ15] Commutation issues async reload; duty updates only with load-ok.
// [RQ16] Async reload aborts triggers, restarts counter, switches list index.
// [RQ17] Enabled trigger unit forwards async reload and a reload to ADCs.
// [RQ18] ADC abort finishes current conversion, then sets sequence-abort flag.
// [RQ19] After abort ADC updates index, fetches first command, resets pointer.
// [RQ20] Without index switch, restarted conversions overwrite old results.
// [RQ21] Commutation compare channel toggles on both edges.
// [RQ22] Second and third reload outputs stay unconnected.
// [RQ23] Async mode lets the frame restart at any instant in the cycle.
// [RQ24] Reload restarts trigger time base and passes to ADCs and gate driver.
// [RQ25] No trigger during up to 7 cycles of trigger fetch after reload.
// [RQ26] No conversion start during up to 10 cycles of command fetch.
// [RQ27] Commutation and reload together: async handling takes precedence.
`timescale 1ns/1ps
`default_nettype none
`include "mcls_consts.svh"
module mcls_top
    import mcls_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [`MCLS_CNT_W-1:0] i_pwm_modulo,
    input wire logic [`MCLS_CNT_W-1:0] i_duty_value,
    input wire logic [`MCLS_DT_W-1:0] i_dead_time,
    input wire logic [3:0] i_reload_periods,
    input wire logic i_pwm_load_ok,
    input wire logic i_global_load_ok_bit,
    input wire logic i_ptu_enable,
    input wire logic i_commut_propagate,
    input wire logic i_commutation_compare_channel,
    input wire logic [4:0] i_gate_fault,
    input wire logic i_gate_fault_clr,
    input wire logic i_pwm_fault_clr,
    input wire logic [`MCLS_CNT_W-1:0] i_trig_time [2][`MCLS_LIST_DEPTH],
    input wire logic [`MCLS_IDX_W-1:0] i_trig_count,
    input wire logic [`MCLS_IDX_W-1:0] i_cmd_count,
    input wire logic i_seq_abort_flag_clr,
    output logic o_pwm_high,
    output logic o_pwm_low,
    output logic o_fet_enable,
    output logic o_reload,
    output logic o_async_reload,
    output logic o_trigger,
    output logic o_adc_conv_start,
    output logic o_conv_done,
    output logic [`MCLS_IDX_W-1:0] o_result_ptr,
    output logic o_trigger_list_index,
    output logic o_adc_list_index,
    output logic o_sequence_abort_flag,
    output logic o_reload_overrun,
    output logic o_gate_fault_flag,
    output logic o_pwm_fault_flag
);
    //------------------------------------------------------------
    // Pin inputs: three flops, change counts when stages 2 and 3 agree
    //------------------------------------------------------------
    logic [2:0] cc_sync_ff;
    logic [2:0] gf_sync_ff [5];
    logic cc_level_ff;
    logic commut_ev;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cc_sync_ff <= 3'h0;
            cc_level_ff <= 1'b0;
        end else begin
            cc_sync_ff <= {cc_sync_ff[1:0], i_commutation_compare_channel};
            if (cc_sync_ff[1] == cc_sync_ff[2])
                cc_level_ff <= cc_sync_ff[2];
        end
    end
    // Toggle channel: either edge is one commutation
    assign commut_ev = (cc_sync_ff[1] == cc_sync_ff[2]) &&
                       (cc_sync_ff[2] != cc_level_ff); // RQ21
    logic fault_now;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < 5; i++)
                gf_sync_ff[i] <= 3'h0;
        end else begin
            for (int i = 0; i < 5; i++)
                gf_sync_ff[i] <= {gf_sync_ff[i][1:0], i_gate_fault[i]};
        end
    end
    always_comb begin
        fault_now = 1'b0;
        for (int i = 0; i < 5; i++)
            fault_now = fault_now | (gf_sync_ff[i][1] & gf_sync_ff[i][2]);
    end

    //------------------------------------------------------------
    // PWM modulator counter, reload divider and duty buffer
    //------------------------------------------------------------
    logic [`MCLS_CNT_W-1:0] pcnt_ff, duty_ff;
    logic [3:0] per_cnt_ff;
    logic period_end, reload_ev, async_ev;
    assign period_end = (pcnt_ff >= i_pwm_modulo);
    assign async_ev = commut_ev && i_commut_propagate; // RQ4
    assign reload_ev = period_end && (per_cnt_ff >= i_reload_periods);
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pcnt_ff <= `MCLS_CNT_RST;
            per_cnt_ff <= 4'h0;
            duty_ff <= `MCLS_CNT_RST;
        end else if (commut_ev) begin
            pcnt_ff <= `MCLS_CNT_RST; // RQ14 RQ23
            per_cnt_ff <= 4'h0;
            if (i_pwm_load_ok)
                duty_ff <= i_duty_value; // RQ15
        end else if (period_end) begin
            pcnt_ff <= `MCLS_CNT_RST;
            per_cnt_ff <= reload_ev ? 4'h0 : per_cnt_ff + 4'h1; // RQ3
            if (reload_ev && i_pwm_load_ok)
                duty_ff <= i_duty_value;
        end else begin
            pcnt_ff <= pcnt_ff + 16'h0001;
        end
    end

    //------------------------------------------------------------
    // Dead time insertion; counter reloaded with the dead time on commutation
    //------------------------------------------------------------
    logic raw_ff;
    logic [`MCLS_DT_W-1:0] dt_cnt_ff;
    logic raw_next;
    assign raw_next = (pcnt_ff < duty_ff);
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            raw_ff <= 1'b0;
            dt_cnt_ff <= 8'h00;
        end else if (commut_ev) begin
            raw_ff <= 1'b0;
            dt_cnt_ff <= i_dead_time; // RQ14
        end else if (raw_next != raw_ff) begin
            raw_ff <= raw_next;
            dt_cnt_ff <= i_dead_time; // RQ1
        end else if (dt_cnt_ff != 8'h00) begin
            dt_cnt_ff <= dt_cnt_ff - 8'h01;
        end
    end

    //------------------------------------------------------------
    // Fault handling: gate fault then PWM fault, resume at period edge or commutation
    //------------------------------------------------------------
    logic drive_ok;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_gate_fault_flag <= 1'b0;
            o_pwm_fault_flag <= 1'b0;
            o_fet_enable <= 1'b0;
        end else begin
            if (fault_now)
                o_gate_fault_flag <= 1'b1; // RQ9
            else if (i_gate_fault_clr)
                o_gate_fault_flag <= 1'b0;
            if (fault_now)
                o_pwm_fault_flag <= 1'b1;
            else if (i_pwm_fault_clr && !o_gate_fault_flag)
                o_pwm_fault_flag <= 1'b0; // RQ10
            if (fault_now || o_gate_fault_flag || o_pwm_fault_flag)
                o_fet_enable <= 1'b0; // RQ9
            else if (period_end || commut_ev)
                o_fet_enable <= 1'b1; // RQ10
        end
    end
    assign drive_ok = o_fet_enable && !fault_now;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pwm_high <= 1'b0;
            o_pwm_low <= 1'b0;
        end else begin
            o_pwm_high <= drive_ok && raw_ff && (dt_cnt_ff == 8'h00);
            o_pwm_low <= drive_ok && !raw_ff && (dt_cnt_ff == 8'h00);
        end
    end

    //------------------------------------------------------------
    // Trigger unit: reload pass-through, list walk, overrun check
    //------------------------------------------------------------
    logic [`MCLS_CNT_W-1:0] tcnt_ff;
    logic [`MCLS_IDX_W-1:0] tidx_ff;
    logic [3:0] tfetch_ff;
    logic tactive_ff, ldok_seen_ff;
    logic any_reload;
    assign any_reload = reload_ev || async_ev;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reload <= 1'b0;
            o_async_reload <= 1'b0;
        end else begin
            // Only the first reload output exists; no second or third
            o_reload <= i_ptu_enable && any_reload; // RQ17 RQ22 RQ24
            o_async_reload <= i_ptu_enable && async_ev; // RQ17
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tcnt_ff <= `MCLS_CNT_RST;
            tidx_ff <= 3'h0;
            tfetch_ff <= 4'h0;
            tactive_ff <= 1'b0;
            o_trigger <= 1'b0;
            o_trigger_list_index <= 1'b0;
        end else if (i_ptu_enable && any_reload) begin
            // Async and plain reload share one restart path
            tcnt_ff <= `MCLS_CNT_RST; // RQ16 RQ24 RQ27
            tidx_ff <= 3'h0;
            tfetch_ff <= `MCLS_PTU_FETCH_CYC; // RQ25
            tactive_ff <= 1'b1;
            o_trigger <= 1'b0; // RQ16
            if (i_global_load_ok_bit)
                o_trigger_list_index <= !o_trigger_list_index; // RQ16
        end else begin
            tcnt_ff <= tcnt_ff + 16'h0001;
            o_trigger <= 1'b0;
            if (tfetch_ff != 4'h0) begin
                tfetch_ff <= tfetch_ff - 4'h1; // RQ25
            end else if (tactive_ff && tidx_ff < i_trig_count &&
                tcnt_ff == i_trig_time[o_trigger_list_index][tidx_ff]) begin
                o_trigger <= 1'b1; // RQ6
                tidx_ff <= tidx_ff + 3'h1;
            end
        end
    end
    // Overrun: reload with no load-ok since the previous one
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ldok_seen_ff <= 1'b0;
            o_reload_overrun <= 1'b0;
        end else if (reload_ev && i_ptu_enable) begin
            ldok_seen_ff <= 1'b0;
            if (!ldok_seen_ff && !i_global_load_ok_bit)
                o_reload_overrun <= 1'b1; // RQ11
        end else if (i_global_load_ok_bit) begin
            ldok_seen_ff <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // ADC sequencer: fetch, convert on trigger, abort on async reload
    //------------------------------------------------------------
    mcls_adc_state_t st_ff;
    logic [3:0] acnt_ff;
    logic [`MCLS_IDX_W-1:0] cmd_ff;
    logic abort_pend_ff, ldok_at_abort_ff;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff <= MCLS_ADC_IDLE;
            acnt_ff <= 4'h0;
            cmd_ff <= 3'h0;
            o_result_ptr <= 3'h0;
            o_adc_list_index <= 1'b0;
            o_adc_conv_start <= 1'b0;
            o_conv_done <= 1'b0;
            abort_pend_ff <= 1'b0;
            ldok_at_abort_ff <= 1'b0;
        end else begin
            o_adc_conv_start <= 1'b0;
            o_conv_done <= 1'b0;
            if (o_async_reload && st_ff == MCLS_ADC_CONV) begin
                abort_pend_ff <= 1'b1; // RQ18 RQ27
                ldok_at_abort_ff <= i_global_load_ok_bit;
            end
            unique case (st_ff)
                MCLS_ADC_IDLE: begin
                    if (o_reload) begin
                        if (o_async_reload && i_global_load_ok_bit)
                            o_adc_list_index <= !o_adc_list_index; // RQ19
                        cmd_ff <= 3'h0;
                        o_result_ptr <= 3'h0; // RQ19 RQ20
                        acnt_ff <= `MCLS_ADC_FETCH_CYC;
                        st_ff <= MCLS_ADC_FETCH;
                    end else if (o_trigger && cmd_ff < i_cmd_count) begin
                        o_adc_conv_start <= 1'b1; // RQ5
                        acnt_ff <= `MCLS_CONV_CYC;
                        st_ff <= MCLS_ADC_CONV;
                    end
                end
                MCLS_ADC_FETCH: begin
                    acnt_ff <= acnt_ff - 4'h1; // RQ26
                    if (acnt_ff == 4'h1)
                        st_ff <= MCLS_ADC_IDLE;
                end
                MCLS_ADC_CONV: begin
                    acnt_ff <= acnt_ff - 4'h1;
                    if (acnt_ff == 4'h1) begin
                        o_conv_done <= 1'b1; // RQ18
                        o_result_ptr <= o_result_ptr + 3'h1;
                        cmd_ff <= cmd_ff + 3'h1; // RQ5
                        st_ff <= (abort_pend_ff || o_async_reload) ?
                            MCLS_ADC_ABORT : MCLS_ADC_IDLE;
                    end
                end
                MCLS_ADC_ABORT: begin
                    abort_pend_ff <= 1'b0;
                    if (ldok_at_abort_ff)
                        o_adc_list_index <= !o_adc_list_index; // RQ19
                    cmd_ff <= 3'h0;
                    o_result_ptr <= 3'h0; // RQ20
                    acnt_ff <= `MCLS_ADC_FETCH_CYC;
                    st_ff <= MCLS_ADC_FETCH;
                end
                default: st_ff <= MCLS_ADC_IDLE;
            endcase
        end
    end
    // Sequence abort flag: setting beats a same-cycle clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            o_sequence_abort_flag <= 1'b0;
        else if (st_ff == MCLS_ADC_ABORT)
            o_sequence_abort_flag <= 1'b1; // RQ18
        else if (i_seq_abort_flag_clr)
            o_sequence_abort_flag <= 1'b0;
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    sequence s_fetch_quiet;
        !o_trigger [*7];
    endsequence
    a_trig_fetch_gap: assert property (@(posedge i_ref_clk) // RQ25
        disable iff (!i_nrst) o_reload |=> s_fetch_quiet)
        else $error("trigger inside fetch window");
    a_adc_fetch_gap: assert property (@(posedge i_ref_clk) // RQ26
        disable iff (!i_nrst) o_reload && st_ff == MCLS_ADC_IDLE
        |=> !o_adc_conv_start [*8])
        else $error("conversion inside fetch window");
    a_fault_off: assert property (@(posedge i_ref_clk) // RQ9
        disable iff (!i_nrst) fault_now |=> !o_fet_enable && !o_pwm_high)
        else $error("outputs active under fault");
    a_async_pass: assert property (@(posedge i_ref_clk) // RQ17
        disable iff (!i_nrst) async_ev && i_ptu_enable
        |=> o_async_reload && o_reload)
        else $error("async reload not forwarded");
    a_abort_flag: assert property (@(posedge i_ref_clk) // RQ18
        disable iff (!i_nrst) o_async_reload && st_ff == MCLS_ADC_CONV
        |-> ##[1:10] o_sequence_abort_flag)
        else $error("abort flag not set");
    a_overrun_set: assert property (@(posedge i_ref_clk) // RQ11
        disable iff (!i_nrst) reload_ev && i_ptu_enable && !ldok_seen_ff
        && !i_global_load_ok_bit |=> o_reload_overrun)
        else $error("overrun not flagged");
    a_commut_restart: assert property (@(posedge i_ref_clk) // RQ14
        disable iff (!i_nrst) commut_ev |=> pcnt_ff == 16'h0000)
        else $error("counter not restarted");
    a_block_commut: assert property (@(posedge i_ref_clk) // RQ4
        disable iff (!i_nrst) commut_ev && !i_commut_propagate
        && !reload_ev |=> !o_async_reload && !o_reload)
        else $error("blocked trigger propagated");
endmodule // mcls_top
`default_nettype wire

// >>> sim/mcls_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Software stand-in: services load-ok after reload
// ------------------------------------------------
module mcls_sw_model (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_reload,
    input wire logic [7:0] i_lag,
    output logic o_load_ok
);
    logic [7:0] wait_ff;
    logic armed_ff;

    // Load-ok rises i_lag cycles after reset and after each reload; a lag
    // longer than the control cycle models service that always comes late
    always @(negedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_ff <= 8'h00;
            armed_ff <= 1'b0;
            o_load_ok <= 1'b0;
        end else if (i_reload) begin
            o_load_ok <= 1'b0;
            wait_ff <= i_lag;
            armed_ff <= 1'b1;
        end else if (!armed_ff) begin
            // Serve the first cycle too, so the first reload is on time
            wait_ff <= i_lag;
            armed_ff <= 1'b1;
        end else if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
            o_load_ok <= (wait_ff == 8'h01);
        end
    end
endmodule // mcls_sw_model
`default_nettype wire

// >>> sim/motor_control_loop_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcls_consts.svh"
module motor_control_loop_sequencer_test;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] modulo = 16'h0031;
    logic [15:0] duty = 16'h0014;
    logic [7:0] dead = 8'h03;
    logic [7:0] lag = 8'hC8;
    logic [3:0] nper = 4'h1;
    logic ptu_en = 1'b1, prop = 1'b1, comm = 1'b0;
    logic [4:0] fault = 5'h00;
    logic g_clr = 1'b0, p_clr = 1'b0, a_clr = 1'b0;
    logic [15:0] ttime [2][8];
    logic [2:0] tcnt = 3'h3;
    logic [2:0] ccnt = 3'h1;
    logic ld_ok, pwm_h, pwm_l, fet_en, rld, arld, trg, cstart, cdone;
    logic [2:0] rptr;
    logic tidx, aidx, sabort, ovr, gflag, pflag;
    int n_mismatch = 0;
    int n_compared = 0;

    mcls_top DUT (.i_ref_clk(ref_clk), .i_nrst(nrst),
        .i_pwm_modulo(modulo), .i_duty_value(duty), .i_dead_time(dead),
        .i_reload_periods(nper), .i_pwm_load_ok(ld_ok),
        .i_global_load_ok_bit(ld_ok), .i_ptu_enable(ptu_en),
        .i_commut_propagate(prop), .i_commutation_compare_channel(comm),
        .i_gate_fault(fault), .i_gate_fault_clr(g_clr),
        .i_pwm_fault_clr(p_clr), .i_trig_time(ttime), .i_trig_count(tcnt),
        .i_cmd_count(ccnt), .i_seq_abort_flag_clr(a_clr),
        .o_pwm_high(pwm_h), .o_pwm_low(pwm_l), .o_fet_enable(fet_en),
        .o_reload(rld), .o_async_reload(arld), .o_trigger(trg),
        .o_adc_conv_start(cstart), .o_conv_done(cdone),
        .o_result_ptr(rptr), .o_trigger_list_index(tidx),
        .o_adc_list_index(aidx), .o_sequence_abort_flag(sabort),
        .o_reload_overrun(ovr), .o_gate_fault_flag(gflag),
        .o_pwm_fault_flag(pflag));

    mcls_sw_model SW (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_reload(rld),
        .i_lag(lag), .o_load_ok(ld_ok));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------
    // Shared helpers
    // ------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return rld;
            1: return trg;
            2: return cstart;
            3: return arld;
            4: return sabort;
            5: return fet_en;
            6: return gflag;
            7: return pwm_h;
            8: return ~pwm_l;
            10: return cdone;
            default: return pwm_l;
        endcase
    endfunction

    // Steps at least one cycle, so a pulse just seen is not seen again
    task automatic wait_for(input int sel, input int lim, output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n > lim) begin
                check("wait_bound", 16'h0000, 16'h0001);
                finish_test();
            end
        end while (pick(sel) !== 1'b1);
    endtask

    task automatic strobe(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("reset_outs", {fet_en, rld, trg, ovr, gflag, tidx}, 16'h0000);
        nrst = 1'b1;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_overrun();
        int n;
        wait_for(0, 300, n);
        wait_for(0, 300, n);
        repeat (2) @(negedge ref_clk);
        check("overrun", ovr, 16'h0001);
        check("idx_held", tidx, 16'h0000);
    endtask

    task automatic t_spacing();
        int n;
        logic t0, a0;
        wait_for(0, 300, n);
        repeat (2) @(negedge ref_clk);
        t0 = tidx;
        a0 = aidx;
        wait_for(0, 300, n);
        check("reload_gap", 16'(n + 2), 16'h0064);
        repeat (2) @(negedge ref_clk);
        check("trig_idx", tidx, {15'h0000, ~t0});
        // ADC lists move only on an async reload, never on a plain reload
        check("adc_idx", aidx, {15'h0000, a0});
        check("no_overrun", ovr, 16'h0000);
    endtask

    task automatic t_triggers();
        int n, c;
        for (int k = 0; k < 2; k++) begin
            tcnt = 3'(3 - k);
            wait_for(0, 300, n);
            wait_for(1, 40, n);
            check("trig_win", 16'(n >= 7 && n <= 14), 16'h0001);
            c = 1;
            for (int i = 0; i < 120 && rld !== 1'b1; i++) begin
                @(negedge ref_clk);
                c += int'(trg === 1'b1);
            end
            if (rld !== 1'b1) begin
                check("reload_bound", 16'h0000, 16'h0001);
                finish_test();
            end
            check("trig_count", 16'(c), 16'(3 - k));
        end
        tcnt = 3'h3;
    endtask

    task automatic t_adc();
        int n;
        wait_for(0, 300, n);
        wait_for(2, 60, n);
        check("conv_delay", 16'(n >= 12 && n <= 16), 16'h0001);
        wait_for(10, 20, n);
        check("conv_len", 16'(n), 16'(`MCLS_CONV_CYC));
        check("result_step", {13'h0000, rptr}, 16'h0001);
    endtask

    // Dead gap is measured from the low side turning off
    task automatic t_dead();
        int n;
        for (int k = 0; k < 2; k++) begin
            dead = 8'(3 + 3 * k);
            wait_for(0, 300, n);
            wait_for(0, 300, n);
            wait_for(9, 120, n);
            wait_for(8, 120, n);
            wait_for(7, 120, n);
            check("dead_time", 16'(n), {8'h00, dead});
        end
    endtask

    task automatic t_faults();
        int n;
        for (int b = 0; b < 5; b++) begin
            wait_for(5, 300, n);
            fault[b] = 1'b1;
            wait_for(6, 10, n);
            repeat (2) @(negedge ref_clk);
            check("fault_off", {fet_en, pwm_h, pwm_l}, 16'h0000);
            fault[b] = 1'b0;
            repeat (5) @(negedge ref_clk);
            strobe(p_clr);
            check("pwm_clr_early", pflag, 16'h0001);
            strobe(g_clr);
            strobe(p_clr);
            check("flags_clr", {gflag, pflag}, 16'h0000);
            wait_for(5, 60, n);
        end
    endtask

    // Cases: blocked, propagated, trigger unit disabled
    task automatic t_commut();
        int c;
        for (int p = 0; p < 3; p++) begin
            prop = (p != 0);
            ptu_en = (p != 2);
            c = 0;
            comm = ~comm;
            for (int i = 0; i < 12; i++) begin
                @(negedge ref_clk);
                c += int'(arld === 1'b1);
            end
            check("async_count", 16'(c), 16'(p == 1));
        end
        ptu_en = 1'b1;
    endtask

    task automatic t_abort();
        int n;
        // An earlier commutation may have aborted a sequence already
        strobe(a_clr);
        wait_for(2, 300, n);
        comm = ~comm;
        wait_for(4, 20, n);
        check("abort_late", 16'(n >= 7), 16'h0001);
        repeat (2) @(negedge ref_clk);
        check("result_ptr", {13'h0000, rptr}, 16'h0000);
        strobe(a_clr);
        check("abort_clr", sabort, 16'h0000);
    endtask

    initial begin
        // Modulo and lists stay fixed from cycle to cycle: a static frame
        // Counts never exceed the lists, so no sequence error can arise
        foreach (ttime[l, e]) begin
            ttime[l][e] = 16'h000C * 16'(e + 1);
        end
        do_reset();
        t_overrun();
        lag = 8'h05;
        do_reset();
        t_spacing();
        t_triggers();
        t_adc();
        t_dead();
        t_faults();
        t_commut();
        t_abort();
        finish_test();
    end
endmodule // motor_control_loop_sequencer_test
`default_nettype wire
